// ### design/edge_detect.sv
`timescale 1ns/10ps
module edge_detect
   import irq_ctrl_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       clk_en,
   input  wire logic       pin_async,
   input  wire logic [1:0] mode,
   output logic            hit
);
   logic [2:0] sync_r;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sync_r <= 3'h0;
      end else if (clk_en) begin
         sync_r <= {sync_r[1:0], pin_async};
      end
   end

   // Only stages 1 and 2 are compared; stage 0 is metastable
   always_comb begin
      case (edge_mode_t'(mode))
         EDGE_RISE: hit = clk_en & sync_r[1] & ~sync_r[2];
         EDGE_FALL: hit = clk_en & ~sync_r[1] & sync_r[2];
         EDGE_BOTH: hit = clk_en & (sync_r[1] ^ sync_r[2]);
         default:   hit = 1'b0;
      endcase
   end
endmodule : edge_detect

// ### design/irq_controller.sv
`timescale 1ns/10ps
module irq_controller
   import irq_ctrl_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       clk_en,
   // Register port
   input  wire logic [2:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Event sources
   input  wire logic       ext_pin_irq,
   input  wire logic       sync_pin,
   input  wire logic       demod_evt,
   input  wire logic       overcurrent_evt,
   input  wire logic       conv_done_evt,
   input  wire logic       tb0_evt,
   input  wire logic       tb1_evt,
   input  wire logic       iic_evt,
   input  wire logic [1:0] tm0_evt,
   input  wire logic [1:0] tm1_evt,
   input  wire logic [1:0] misc_evt,
   // Core side
   input  wire logic       stack_full,
   input  wire logic       irq_ack,
   output logic            irq_req,
   output logic      [7:0] irq_vector,
   output logic            wake
);
   logic [7:0] edge_select_r;
   logic [7:0] pc0_r;
   logic [7:0] pc1_r;
   logic [7:0] pc2_r;
   logic [7:0] grp_r [3];
   logic       pin_hit;
   logic       sync_hit;
   logic [NUM_VEC-1:0] pend;
   logic [7:0] vec_nxt;
   logic       any_nxt;
   logic [16:0] flags_now;
   logic [16:0] flags_prev_r;
   logic [2:0]  grp_pend;
   logic       ack_taken;
   logic       pin_taken;

   // ---------------------------------------------
   // Pin edge detectors
   // ---------------------------------------------
   edge_detect u_pin (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .clk_en    (clk_en),
      .pin_async (ext_pin_irq),
      .mode      (edge_select_r[PIN_SEL_LSB+1:PIN_SEL_LSB]),
      .hit       (pin_hit)
   );
   // Only falling mode is dependable here; software must choose it
   edge_detect u_sync (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .clk_en    (clk_en),
      .pin_async (sync_pin),
      .mode      (edge_select_r[SYNC_SEL_LSB+1:SYNC_SEL_LSB]),
      .hit       (sync_hit)
   );

   // ---------------------------------------------
   // Group combining
   // ---------------------------------------------
   always_comb begin
      grp_pend = 3'h0;
      for (int g = 0; g < 3; g++) begin
         grp_pend[g] = |(grp_r[g][5:4] & grp_r[g][1:0]);
      end
   end

   // ---------------------------------------------
   // Priority selection
   // ---------------------------------------------
   always_comb begin
      pend = '0;
      pend[SRC_PIN]  = pc2_r[7] & pc2_r[3];
      pend[SRC_SYNC] = pc0_r[6] & pc0_r[3];
      pend[SRC_OCP]  = pc0_r[4] & pc0_r[1];
      pend[SRC_DEM]  = pc0_r[5] & pc0_r[2];
      pend[SRC_GRP0] = pc1_r[4] & pc1_r[0];
      pend[SRC_GRP1] = pc1_r[5] & pc1_r[1];
      pend[SRC_GRP2] = pc1_r[6] & pc1_r[2];
      pend[SRC_CONV] = pc1_r[7] & pc1_r[3];
      pend[SRC_TB0]  = pc2_r[5] & pc2_r[1];
      pend[SRC_TB1]  = pc2_r[6] & pc2_r[2];
      pend[SRC_IIC]  = pc2_r[4] & pc2_r[0];
      vec_nxt = VEC_BASE;
      any_nxt = 1'b0;
      for (int i = NUM_VEC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            vec_nxt = VEC_BASE + VEC_STEP * 8'(i);
            any_nxt = 1'b1;
         end
      end
   end

   // Request held off by global enable and a full stack
   assign irq_req = any_nxt & pc0_r[GIE_BIT] & ~stack_full;
   // Core takes the request on the edge where it sees both high
   assign ack_taken = irq_req & irq_ack;
   // Pin is top priority, so a taken request with pin pending is the pin's
   assign pin_taken = ack_taken & pend[SRC_PIN];

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq_vector <= VEC_BASE;
      end else if (clk_en) begin
         irq_vector <= vec_nxt;
      end
   end

   // ---------------------------------------------
   // Registers; hardware set beats software clear
   // ---------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         edge_select_r <= RESET_VAL;
      end else if (clk_en && reg_wr && reg_addr == ADDR_EDGE) begin
         edge_select_r <= reg_wdata & EDGE_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pc0_r <= RESET_VAL;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == ADDR_PC0) begin
            pc0_r <= reg_wdata & PC0_MASK;
         end else if (ack_taken) begin
            pc0_r[GIE_BIT] <= 1'b0;
         end
         if (sync_hit) pc0_r[6] <= 1'b1;
         if (demod_evt) pc0_r[5] <= 1'b1;
         if (overcurrent_evt) pc0_r[4] <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pc1_r <= RESET_VAL;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == ADDR_PC1) begin
            pc1_r <= reg_wdata;
         end
         if (conv_done_evt) pc1_r[7] <= 1'b1;
         // Group flag sticks; software clears the members first
         for (int g = 0; g < 3; g++) begin
            if (grp_pend[g]) pc1_r[FLAG_LSB+g] <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pc2_r <= RESET_VAL;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == ADDR_PC2) begin
            pc2_r <= reg_wdata;
         end else if (pin_taken) begin
            pc2_r[7] <= 1'b0;
         end
         if (pin_hit) pc2_r[7] <= 1'b1;
         if (tb0_evt) pc2_r[5] <= 1'b1;
         if (tb1_evt) pc2_r[6] <= 1'b1;
         if (iic_evt) pc2_r[4] <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int g = 0; g < 3; g++) grp_r[g] <= RESET_VAL;
      end else if (clk_en) begin
         for (int g = 0; g < 3; g++) begin
            if (reg_wr && reg_addr == ADDR_GRP0 + 3'(g)) begin
               grp_r[g] <= reg_wdata & GRP_MASK;
            end
         end
         if (tm0_evt[0]) grp_r[0][4] <= 1'b1;
         if (tm0_evt[1]) grp_r[0][5] <= 1'b1;
         if (tm1_evt[0]) grp_r[1][4] <= 1'b1;
         if (tm1_evt[1]) grp_r[1][5] <= 1'b1;
         if (misc_evt[0]) grp_r[2][4] <= 1'b1;
         if (misc_evt[1]) grp_r[2][5] <= 1'b1;
      end
   end

   // ---------------------------------------------
   // Read back and wake
   // ---------------------------------------------
   always_comb begin
      // Unmapped indices read as zero
      if (reg_addr == ADDR_EDGE) reg_rdata = edge_select_r;
      else if (reg_addr == ADDR_PC0) reg_rdata = pc0_r;
      else if (reg_addr == ADDR_PC1) reg_rdata = pc1_r;
      else if (reg_addr == ADDR_PC2) reg_rdata = pc2_r;
      else if (reg_addr == ADDR_GRP0) reg_rdata = grp_r[0];
      else if (reg_addr == ADDR_GRP1) reg_rdata = grp_r[1];
      else if (reg_addr == ADDR_GRP2) reg_rdata = grp_r[2];
      else reg_rdata = 8'h00;
   end

   // Group member flags count too: a masked member still wakes the core
   assign flags_now = {pc0_r[6:4], pc1_r[7:4], pc2_r[7:4],
                       grp_r[2][5:4], grp_r[1][5:4], grp_r[0][5:4]};

   // Wake is a one-cycle pulse on any flag rising
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         flags_prev_r <= '0;
         wake         <= 1'b0;
      end else if (clk_en) begin
         flags_prev_r <= flags_now;
         wake         <= |(flags_now & ~flags_prev_r);
      end
   end
endmodule : irq_controller

// ### design/irq_ctrl_pkg.sv
// Contract
// - Each source has request flag and enable
// - Global enable bit 0 gates everything; the code gates only irq_req, not flag setting or wake
// - Pin edges and internal events raise requests
// - Pin edge field: off, rise, fall, both
// - Sync edge field uses same encoding
// - Sync flag bit 6, enable bit 3
// - Demod flag bit 5, enable bit 2
// - Overcurrent flag bit 4, enable 1; bit7 zero
// - Conversion flag bit 7, enable bit 3
// - Group registers combine into one flag each
// - Implemented bits read/write, reset zero
// - Jump only when flag, enable, global set
// - Service clears global enable; flags still record
// - Pin flag cleared on service; full stack blocks
// - Any set flag wakes from sleep, idle
package irq_ctrl_pkg;
   // ---------------------------------------------
   // Register indices
   // ---------------------------------------------
   localparam logic [2:0] ADDR_EDGE  = 3'h0;
   localparam logic [2:0] ADDR_PC0   = 3'h1;
   localparam logic [2:0] ADDR_PC1   = 3'h2;
   localparam logic [2:0] ADDR_PC2   = 3'h3;
   localparam logic [2:0] ADDR_GRP0  = 3'h4;
   localparam logic [2:0] ADDR_GRP1  = 3'h5;
   localparam logic [2:0] ADDR_GRP2  = 3'h6;
   // ---------------------------------------------
   // Field positions and resets
   // ---------------------------------------------
   localparam int PIN_SEL_LSB  = 2;
   localparam int SYNC_SEL_LSB = 0;
   localparam int GIE_BIT      = 0;
   localparam int FLAG_LSB     = 4;
   localparam logic [7:0] RESET_VAL = 8'h00;
   localparam logic [7:0] PC0_MASK  = 8'h7F;
   localparam logic [7:0] EDGE_MASK = 8'h0F;
   localparam logic [7:0] GRP_MASK  = 8'h33;
   // ---------------------------------------------
   // Edge select encoding
   // ---------------------------------------------
   typedef enum logic [1:0] {
      EDGE_OFF  = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } edge_mode_t;
   // Source numbering, priority high to low
   localparam int NUM_SRC   = 11;
   localparam int SRC_PIN   = 0;
   localparam int SRC_SYNC  = 1;
   localparam int SRC_OCP   = 2;
   localparam int SRC_DEM   = 3;
   localparam int SRC_GRP0  = 4;
   localparam int SRC_GRP1  = 5;
   localparam int SRC_GRP2  = 6;
   localparam int SRC_CONV  = 7;
   localparam int SRC_TB0   = 8;
   localparam int SRC_TB1   = 9;
   localparam int SRC_IIC   = 10;
   localparam int NUM_VEC   = 11;
   localparam logic [7:0] VEC_BASE = 8'h04;
   localparam logic [7:0] VEC_STEP = 8'h04;
endpackage : irq_ctrl_pkg

// ### test/core_model.sv
`timescale 1ns/10ps
// ---------------------------------------------
// Core sequencer model
// ---------------------------------------------
module core_model (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       irq_req,
   input  wire logic [7:0] irq_vector,
   input  wire logic       full_in,
   input  wire logic       ack_on,
   output logic            stack_full,
   output logic            irq_ack,
   output logic      [7:0] taken_vec
);
   logic seen_r;
   assign stack_full = full_in;
   // Waits a cycle: the vector output lags the request
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         seen_r    <= 1'b0;
         irq_ack   <= 1'b0;
         taken_vec <= 8'h00;
      end else begin
         seen_r  <= irq_req && !irq_ack;
         irq_ack <= irq_req && seen_r && ack_on && !irq_ack;
         if (irq_req && seen_r && ack_on && !irq_ack) taken_vec <= irq_vector;
      end
   end
endmodule : core_model

// ### test/irq_controller_sva.sv
`timescale 1ns/10ps
// ---------------------------------------------
// Port checker
// ---------------------------------------------
module irq_controller_chk
   import irq_ctrl_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       reset,
   input wire logic       clk_en,
   input wire logic [2:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       stack_full,
   input wire logic       irq_ack,
   input wire logic       irq_req,
   input wire logic [7:0] irq_vector
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   edge_mask_a: assert property (reg_addr == ADDR_EDGE |-> reg_rdata[7:4] == 4'h0)
      else $error("edge reserved bits set");
   pc0_mask_a: assert property (reg_addr == ADDR_PC0 |-> !reg_rdata[7])
      else $error("pc0 bit 7 set");
   grp_mask_a: assert property (reg_addr >= ADDR_GRP0 && reg_addr <= ADDR_GRP2
      |-> (reg_rdata & ~GRP_MASK) == 8'h00) else $error("group reserved bits set");
   gie_gate_a: assert property (reg_addr == ADDR_PC0 && !reg_rdata[GIE_BIT] |-> !irq_req)
      else $error("request with global enable off");
   stack_block_a: assert property (stack_full |-> !irq_req)
      else $error("request while stack full");
   ack_clear_a: assert property (irq_ack && clk_en && !(reg_wr && reg_addr == ADDR_PC0)
      |=> !irq_req) else $error("request after acknowledge");
   edge_rw_a: assert property (clk_en && reg_wr && reg_addr == ADDR_EDGE ##1
      reg_addr == ADDR_EDGE |-> reg_rdata == {4'h0, $past(reg_wdata[3:0])})
      else $error("edge readback wrong");
   vec_range_a: assert property (irq_req |-> irq_vector[1:0] == 2'h0 &&
      irq_vector >= VEC_BASE && irq_vector <= 8'h2C) else $error("vector out of range");
   reset_val_a: assert property (disable iff (1'b0) reset |=> irq_vector == VEC_BASE
      && !irq_req) else $error("reset values wrong");
endmodule : irq_controller_chk

bind irq_controller irq_controller_chk chk (.ref_clk, .reset, .clk_en, .reg_addr, .reg_wr,
   .reg_wdata, .reg_rdata, .stack_full, .irq_ack, .irq_req, .irq_vector);

// ### test/irq_controller_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module irq_controller_tb_top;
   import irq_ctrl_pkg::*;
   logic       ref_clk, reset, reg_wr, ext_pin_irq, sync_pin, demod_evt;
   logic       overcurrent_evt, conv_done_evt, iic_evt, stack_full, irq_ack;
   logic       irq_req, wake, full_in, ack_on, clk_en;
   logic [1:0] tm0_evt;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, irq_vector, taken_vec;
   int         failures, checks_done;
   irq_controller uut (.ref_clk, .reset, .clk_en, .reg_addr, .reg_wr, .reg_wdata,
      .reg_rdata, .ext_pin_irq, .sync_pin, .demod_evt, .overcurrent_evt, .conv_done_evt,
      .tb0_evt(1'b0), .tb1_evt(1'b0), .iic_evt, .tm0_evt, .tm1_evt(2'h0), .misc_evt(2'h0),
      .stack_full, .irq_ack, .irq_req, .irq_vector, .wake);
   core_model core (.ref_clk, .reset, .irq_req, .irq_vector, .full_in, .ack_on,
      .stack_full, .irq_ack, .taken_vec);
   // ---------------------------------------------
   // Bus helpers
   // ---------------------------------------------
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
      @(posedge ref_clk) reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge ref_clk) reg_addr <= a;
      @(negedge ref_clk) `CHK(reg_rdata, e)
   endtask : rd
   task wait_ack(input logic [7:0] v);
      for (int i = 0; i < 20 && irq_ack !== 1'b1; i++) @(negedge ref_clk);
      `CHK(irq_ack, 1'b1)
      @(negedge ref_clk) `CHK(taken_vec, v)
   endtask : wait_ack
   task close_out;
      if (failures == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task t_reset;
      for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
      `CHK(irq_vector, VEC_BASE)
   endtask : t_reset
   task t_mask;
      wr(ADDR_EDGE, 8'hFF); rd(ADDR_EDGE, 8'h0F);
      wr(ADDR_PC0, 8'hFE); rd(ADDR_PC0, 8'h7E);
      wr(ADDR_GRP0, 8'hFF); rd(ADDR_GRP0, 8'h33);
      wr(ADDR_GRP0, 8'h00); wr(ADDR_PC1, 8'h00); wr(ADDR_PC0, 8'h00); wr(ADDR_EDGE, 8'h00);
   endtask : t_mask
   task t_conv;
      int w;
      ack_on <= 1'b1; w = 0;
      wr(ADDR_PC1, 8'h08); wr(ADDR_PC0, 8'h01);
      @(posedge ref_clk) conv_done_evt <= 1'b1;
      @(posedge ref_clk) conv_done_evt <= 1'b0;
      repeat (3) @(negedge ref_clk) w = w | wake;
      `CHK(w, 1)
      wait_ack(8'h20);
      rd(ADDR_PC0, 8'h00); rd(ADDR_PC1, 8'h88);
      @(posedge ref_clk) overcurrent_evt <= 1'b1;
      @(posedge ref_clk) overcurrent_evt <= 1'b0;
      rd(ADDR_PC0, 8'h10); `CHK(irq_req, 1'b0)
      wr(ADDR_PC0, 8'h00); wr(ADDR_PC1, 8'h00);
   endtask : t_conv
   task t_stack;
      full_in <= 1'b1; wr(ADDR_PC0, 8'h07);
      @(posedge ref_clk) begin demod_evt <= 1'b1; overcurrent_evt <= 1'b1; end
      @(posedge ref_clk) begin demod_evt <= 1'b0; overcurrent_evt <= 1'b0; end
      repeat (3) @(negedge ref_clk); `CHK(irq_req, 1'b0)
      @(posedge ref_clk) full_in <= 1'b0;
      wait_ack(8'h0C);
      wr(ADDR_PC0, 8'h00);
   endtask : t_stack
   task t_pin;
      wr(ADDR_EDGE, 8'h0A); wr(ADDR_PC2, 8'h08); wr(ADDR_PC0, 8'h01);
      @(posedge ref_clk) ext_pin_irq <= 1'b1;
      repeat (5) @(negedge ref_clk); `CHK(irq_req, 1'b0)
      @(posedge ref_clk) ext_pin_irq <= 1'b0;
      wait_ack(VEC_BASE); rd(ADDR_PC2, 8'h08);
      @(posedge ref_clk) sync_pin <= 1'b1;
      repeat (5) @(posedge ref_clk); sync_pin <= 1'b0;
      @(posedge ref_clk) iic_evt <= 1'b1;
      @(posedge ref_clk) iic_evt <= 1'b0;
      repeat (4) @(posedge ref_clk); rd(ADDR_PC0, 8'h40); rd(ADDR_PC2, 8'h18);
      wr(ADDR_PC0, 8'h00); wr(ADDR_GRP0, 8'h01);
      @(posedge ref_clk) tm0_evt <= 2'h3;
      @(posedge ref_clk) tm0_evt <= 2'h0;
      rd(ADDR_GRP0, 8'h31); rd(ADDR_PC1, 8'h10);
   endtask : t_pin
   task t_vec;
      wr(ADDR_PC1, 8'h11); wr(ADDR_PC0, 8'h01);
      wait_ack(8'h14);
      wr(ADDR_GRP0, 8'h00); wr(ADDR_PC1, 8'h00);
      wr(ADDR_EDGE, 8'h02); wr(ADDR_PC0, 8'h09);
      @(posedge ref_clk) sync_pin <= 1'b1;
      repeat (4) @(posedge ref_clk); sync_pin <= 1'b0;
      wait_ack(8'h08);
      wr(ADDR_PC0, 8'h00);
   endtask : t_vec
   task t_edges;
      wr(ADDR_PC2, 8'h00); wr(ADDR_EDGE, 8'h04);
      @(posedge ref_clk) ext_pin_irq <= 1'b1;
      repeat (3) @(posedge ref_clk); rd(ADDR_PC2, 8'h80);
      wr(ADDR_PC2, 8'h00);
      @(posedge ref_clk) ext_pin_irq <= 1'b0;
      repeat (3) @(posedge ref_clk); rd(ADDR_PC2, 8'h00);
      wr(ADDR_EDGE, 8'h0C);
      @(posedge ref_clk) ext_pin_irq <= 1'b1;
      repeat (3) @(posedge ref_clk); rd(ADDR_PC2, 8'h80);
      wr(ADDR_PC2, 8'h00);
      @(posedge ref_clk) ext_pin_irq <= 1'b0;
      repeat (3) @(posedge ref_clk); rd(ADDR_PC2, 8'h80);
      wr(ADDR_PC2, 8'h00); wr(ADDR_EDGE, 8'h00);
   endtask : t_edges
   task t_freeze;
      @(posedge ref_clk) clk_en <= 1'b0;
      wr(ADDR_PC0, 8'h24);
      @(posedge ref_clk) demod_evt <= 1'b1;
      @(posedge ref_clk) begin demod_evt <= 1'b0; clk_en <= 1'b1; end
      rd(ADDR_PC0, 8'h00);
   endtask : t_freeze
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      #200000 failures++;
      close_out();
   end
   initial begin
      {reset, reg_wr, ext_pin_irq, sync_pin, demod_evt, overcurrent_evt} = 6'h20;
      {conv_done_evt, iic_evt, full_in, ack_on, tm0_evt} = 6'h00;
      reg_addr = 3'h0; reg_wdata = 8'h00; failures = 0; checks_done = 0;
      clk_en = 1'b1;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset(); t_mask(); t_conv(); t_stack(); t_pin();
      t_vec(); t_edges(); t_freeze();
      close_out();
   end
endmodule : irq_controller_tb_top
